// *** fcs_sequencer.sv ***
// What this block does
// [RULE1] Status read during program returns inverted written data on poll bit.
// [RULE2] After program completes, poll bit shows true cell data again.
// [RULE3] Erase: poll bit reads 0 while running, cell value 1 after.
// [RULE4] Status output starts right after the final command write.
// [RULE5] After failure the poll bit keeps its running value.
// [RULE6] Toggle bit alternates on every status read until the end.
// [RULE7] After failure the toggle bit keeps alternating.
// [RULE8] Timeout bit is 0 while running, 1 past the time limit.
// [RULE9] Programming a 1 over a 0 ends in the timeout failure.
// [RULE10] After failure stay out of read mode until reset command.
// [RULE11] Software polls the programmed or an erased unprotected address.
// [RULE12] Block erase waits the hold time; erase timer bit 0 then 1.
// [RULE13] Ready/busy flag bit 2: 0 busy, 1 ready, 1 after reset.
// [RULE14] Ready/busy flag stays 0 forever after a failed operation; here a reset command sets it back to 1.
// [RULE15] Busy starts at final write, or after hold for block erase.
// [RULE16] All command writes are ignored while ready/busy reads 0; in ST_FAIL a reset command is still taken.
// [RULE17] Security enable register arms chip erase with unprotect.
// [RULE18] Byte F0 to an address with low nibble zero resets to read; here not in ST_BUSY, and in ST_PROGRAM it is taken as program data.
// [RULE19] Program: AA, 55, A0, then address and data.
// [RULE20] Chip erase: AA, 55, 80, AA, 55, 10 on the unlock addresses.
// [RULE21] Block erase: same five writes, then 30 inside the block.
// [RULE22] Protect: AA, 55, 9A, AA, 55, then 70 inside the block.
// [RULE23] Verify: AA, 55, 90, then reads return protection data.
// [RULE24] Verify read gives 1 for protected and 0 for unprotected block.
// [RULE25] Software spaces command cycles by at least two instructions.
// [RULE26] A wrong address or data abandons the sequence to read mode.
// [RULE27] Decoding stays idle until ready or reset command or reset.
`timescale 1ns/1ps
`default_nettype none

module fcs_sequencer #(
  parameter int ADDR_W = fcs_pkg::ADDR_W,
  parameter int HOLD_CYCLES = fcs_pkg::ERASE_HOLD_CYC,
  parameter int TIMEOUT_CYCLES = fcs_pkg::OP_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fcs_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic flashWrite,
  input wire logic flashRead,
  input wire logic [ADDR_W-1:0] flashAddr,
  input wire logic [31:0] flashWdata,
  output logic [31:0] flashRdata,
  input wire logic [31:0] cellData,
  input wire logic addrProtected,
  output logic opStart,
  output fcs_pkg::fcs_op_type opKind,
  output logic [ADDR_W-1:0] opAddr,
  output logic [31:0] opData,
  input wire logic opDone,
  input wire logic opError,
  output logic readyBusyOutput
);
  import fcs_pkg::*;

  localparam int HOLD_W = $clog2(HOLD_CYCLES + 1);
  localparam int TIME_W = $clog2(TIMEOUT_CYCLES + 1);

  typedef enum logic [3:0] {
    ST_READ = 4'h0,
    ST_UNLOCK1 = 4'h1,
    ST_UNLOCK2 = 4'h3,
    ST_SETUP = 4'h2,
    ST_UNLOCK3 = 4'h6,
    ST_UNLOCK4 = 4'h7,
    ST_HOLD = 4'h5,
    ST_BUSY = 4'h4,
    ST_FAIL = 4'hC,
    ST_PROGRAM = 4'hB,
    ST_VERIFY = 4'hF
  } fcs_state_type;

  fcs_state_type state;
  fcs_state_type next_state;
  fcs_op_type commitKind;
  logic commit;
  logic protectSeq;
  logic next_protectSeq;
  logic forcedFail;
  logic badProgram;
  logic toggleBit;
  logic readyBusy;
  logic [7:0] securityEnable;
  logic [7:0] cmdByte;
  logic resetHit;
  logic statusMode;
  logic statusRead;
  logic holdLoad;
  logic holdDone;
  logic timeLoad;
  logic timeDone;
  logic [31:0] statusWord;

  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic logic cycleIs(input logic [15:0] addr,
                                   input logic [7:0] data,
                                   input logic [15:0] expAddr,
                                   input logic [7:0] expData);
    return (addr == expAddr) && (data == expData);
  endfunction

  function automatic logic isErase(input fcs_op_type kind);
    return (kind == OP_CHIP_ERASE) || (kind == OP_CHIP_UNPROTECT) ||
           (kind == OP_BLOCK_ERASE);
  endfunction

  assign cmdByte = flashWdata[7:0];
  assign resetHit = (cmdByte == CMD_RESET) && (flashAddr[3:0] == 4'h0);
  assign statusMode = (state == ST_HOLD) || (state == ST_BUSY) ||
                      (state == ST_FAIL);
  assign statusRead = flashRead && statusMode;
  assign badProgram = |(flashWdata & ~cellData);

  // ==========================================================
  // Register slave
  // ==========================================================
  fcs_apb_regs u_regs (
    .clk(clk),
    .rst_n(rst_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .readyBusy(readyBusy),
    .securityEnable(securityEnable)
  );

  // ==========================================================
  // Timers: erase hold and the internal time limit
  // ==========================================================
  assign holdLoad = (state != ST_HOLD) && (next_state == ST_HOLD);
  assign timeLoad = (state != ST_BUSY) && (next_state == ST_BUSY);

  fcs_down_timer #(.WIDTH(HOLD_W)) u_hold (
    .clk(clk),
    .rst_n(rst_n),
    .load(holdLoad),
    .loadValue(HOLD_W'(HOLD_CYCLES)),
    .clear(next_state != ST_HOLD),
    .done(holdDone)
  );

  fcs_down_timer #(.WIDTH(TIME_W)) u_limit (
    .clk(clk),
    .rst_n(rst_n),
    .load(timeLoad),
    .loadValue(TIME_W'(TIMEOUT_CYCLES)),
    .clear(next_state != ST_BUSY),
    .done(timeDone)
  );

  // ==========================================================
  // Command decoder
  // ==========================================================
  always_comb begin
    next_state = state;
    next_protectSeq = protectSeq;
    commit = 1'b0;
    commitKind = OP_PROGRAM;
    case (state)
      ST_READ: begin
        if (flashWrite) begin
          next_state = cycleIs(flashAddr[15:0], cmdByte, ADDR_UNLOCK_A,
                               CMD_UNLOCK_A) ? ST_UNLOCK1 : ST_READ;
        end
      end
      ST_UNLOCK1: begin
        if (flashWrite) begin // see [RULE26]
          next_state = cycleIs(flashAddr[15:0], cmdByte, ADDR_UNLOCK_B,
                               CMD_UNLOCK_B) ? ST_UNLOCK2 : ST_READ;
        end
      end
      ST_UNLOCK2: begin
        next_protectSeq = 1'b0;
        if (flashWrite) begin
          next_state = ST_READ;
          if (flashAddr[15:0] == ADDR_UNLOCK_A) begin
            if (cmdByte == CMD_PROGRAM) begin // see [RULE19]
              next_state = ST_PROGRAM;
            end else if (cmdByte == CMD_ERASE_SETUP) begin // see [RULE20]
              next_state = ST_SETUP;
            end else if (cmdByte == CMD_PROTECT_SETUP) begin // see [RULE22]
              next_state = ST_SETUP;
              next_protectSeq = 1'b1;
            end else if (cmdByte == CMD_VERIFY) begin // see [RULE23]
              next_state = ST_VERIFY;
            end
          end
        end
      end
      ST_SETUP: begin
        if (flashWrite) begin
          next_state = cycleIs(flashAddr[15:0], cmdByte, ADDR_UNLOCK_A,
                               CMD_UNLOCK_A) ? ST_UNLOCK3 : ST_READ;
        end
      end
      ST_UNLOCK3: begin
        if (flashWrite) begin
          next_state = cycleIs(flashAddr[15:0], cmdByte, ADDR_UNLOCK_B,
                               CMD_UNLOCK_B) ? ST_UNLOCK4 : ST_READ;
        end
      end
      ST_UNLOCK4: begin
        if (flashWrite) begin
          next_state = ST_READ;
          if (protectSeq) begin
            if (cmdByte == CMD_PROTECT_GO) begin // see [RULE22]
              next_state = ST_BUSY;
              commit = 1'b1;
              commitKind = OP_PROTECT;
            end
          end else if (cycleIs(flashAddr[15:0], cmdByte, ADDR_UNLOCK_A,
                               CMD_CHIP_ERASE)) begin // see [RULE20]
            next_state = ST_BUSY;
            commit = 1'b1;
            commitKind = (securityEnable != 8'h00) ? OP_CHIP_UNPROTECT
                                                   : OP_CHIP_ERASE; // see [RULE17]
          end else if (cmdByte == CMD_BLOCK_ERASE) begin // see [RULE21]
            next_state = ST_HOLD; // see [RULE12] [RULE15]
            commit = 1'b1;
            commitKind = OP_BLOCK_ERASE;
          end
        end
      end
      ST_PROGRAM: begin
        if (flashWrite) begin
          // A protected target is refused quietly back to read mode
          next_state = addrProtected ? ST_READ : ST_BUSY; // see [RULE19]
          commit = !addrProtected;
          commitKind = OP_PROGRAM;
        end
      end
      ST_VERIFY: begin
        next_state = ST_VERIFY;
      end
      ST_HOLD: begin
        if (holdDone) begin
          next_state = ST_BUSY; // see [RULE12]
        end else if (flashWrite) begin
          next_state = ST_READ;
        end
      end
      ST_BUSY: begin // see [RULE16] [RULE27]
        if (opDone && !forcedFail) begin
          next_state = opError ? ST_FAIL : ST_READ;
        end else if (timeDone) begin
          next_state = ST_FAIL; // see [RULE8]
        end
      end
      ST_FAIL: begin
        next_state = ST_FAIL; // see [RULE10] [RULE14]
      end
      default: begin
        next_state = ST_READ;
      end
    endcase
    // A running operation only ends by itself or by hardware reset;
    // program data whose low byte looks like the reset code is still data
    if (flashWrite && resetHit && state != ST_BUSY &&
        state != ST_PROGRAM) begin // see [RULE18]
      next_state = ST_READ;
      commit = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_READ;
      protectSeq <= 1'b0;
    end else begin
      state <= next_state;
      protectSeq <= next_protectSeq;
    end
  end

  // ==========================================================
  // Operation latch and engine start
  // ==========================================================
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      opKind <= OP_PROGRAM;
      opAddr <= '0;
      opData <= '0;
    end else if (commit) begin
      opKind <= commitKind;
      opAddr <= flashAddr;
      opData <= flashWdata;
    end
  end

  // The engine never starts on a 0-to-1 program; the limit then fires
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      forcedFail <= 1'b0;
    end else if (commit) begin
      forcedFail <= (commitKind == OP_PROGRAM) && badProgram; // see [RULE9]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      opStart <= 1'b0;
    end else begin
      opStart <= (commit && next_state == ST_BUSY &&
                  !(commitKind == OP_PROGRAM && badProgram)) ||
                 (state == ST_HOLD && next_state == ST_BUSY);
    end
  end

  // ==========================================================
  // Status flags
  // ==========================================================
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readyBusy <= STATUS_READY_RESET;
    end else begin // see [RULE13] [RULE15]
      readyBusy <= !(next_state == ST_BUSY || next_state == ST_FAIL);
    end
  end

  assign readyBusyOutput = readyBusy;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      toggleBit <= 1'b0;
    end else if (commit) begin
      toggleBit <= 1'b0;
    end else if (statusRead) begin
      toggleBit <= !toggleBit; // see [RULE6] [RULE7]
    end
  end

  always_comb begin
    statusWord = '0;
    statusWord[POLL_POS] = (opKind == OP_PROGRAM) ?
                           !opData[POLL_POS] : 1'b0; // see [RULE1] [RULE3] [RULE5]
    statusWord[TOGGLE_POS] = toggleBit;
    statusWord[TIMEOUT_POS] = (state == ST_FAIL); // see [RULE8]
    statusWord[ERASE_TIMER_POS] = (state != ST_HOLD) &&
                                  isErase(opKind); // see [RULE12]
  end

  // ==========================================================
  // Read path
  // ==========================================================
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flashRdata <= '0;
    end else if (flashRead) begin
      if (statusMode) begin
        flashRdata <= statusWord; // see [RULE4] [RULE10]
      end else if (state == ST_VERIFY) begin
        flashRdata <= addrProtected ? VERIFY_PROTECTED
                                    : VERIFY_UNPROTECTED; // see [RULE24]
      end else begin
        flashRdata <= cellData; // see [RULE2]
      end
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  prog_poll_a: assert property ( // see [RULE1]
    statusRead && opKind == OP_PROGRAM
    |=> flashRdata[POLL_POS] == !$past(opData[POLL_POS]))
    else $error("poll bit not inverted program data");

  cell_read_a: assert property ( // see [RULE2]
    flashRead && state == ST_READ |=> flashRdata == $past(cellData))
    else $error("read mode does not return cell data");

  erase_poll_a: assert property ( // see [RULE3]
    statusRead && isErase(opKind) |=> !flashRdata[POLL_POS])
    else $error("poll bit not zero during erase");

  status_start_a: assert property ( // see [RULE4]
    commit && next_state == ST_BUSY |=> statusMode && !readyBusy)
    else $error("status mode late after final write");

  toggle_alt_a: assert property ( // see [RULE6]
    statusRead ##1 statusRead
    |=> flashRdata[TOGGLE_POS] != $past(flashRdata[TOGGLE_POS]))
    else $error("toggle bit did not alternate");

  limit_fail_a: assert property ( // see [RULE8]
    state == ST_BUSY && timeDone && !(opDone && !forcedFail)
    |=> state == ST_FAIL ##1 (!statusRead || statusWord[TIMEOUT_POS]))
    else $error("time limit did not flag failure");

  bad_prog_a: assert property ( // see [RULE9]
    state == ST_PROGRAM && flashWrite && !addrProtected && badProgram &&
    !resetHit |=> state == ST_BUSY && !opStart)
    else $error("zero-to-one program started the engine");

  fail_lock_a: assert property ( // see [RULE14]
    state == ST_FAIL && !(flashWrite && resetHit)
    |=> state == ST_FAIL && !readyBusy)
    else $error("failed operation left the locked state");

  hold_flag_a: assert property ( // see [RULE12]
    holdLoad |=> state == ST_HOLD && readyBusy && !statusWord[ERASE_TIMER_POS])
    else $error("erase hold entry wrong");

  busy_ignore_a: assert property ( // see [RULE16]
    state == ST_BUSY && !timeDone && !opDone |=> state == ST_BUSY)
    else $error("command accepted while busy");

  reset_cmd_a: assert property ( // see [RULE18]
    flashWrite && resetHit && state != ST_BUSY && state != ST_PROGRAM
    |=> state == ST_READ)
    else $error("reset command did not restore read mode");

  seq_abort_a: assert property ( // see [RULE26]
    state == ST_UNLOCK1 && flashWrite && !resetHit &&
    !cycleIs(flashAddr[15:0], cmdByte, ADDR_UNLOCK_B, CMD_UNLOCK_B)
    |=> state == ST_READ)
    else $error("broken sequence not abandoned");

  verify_data_a: assert property ( // see [RULE24]
    flashRead && state == ST_VERIFY
    |=> flashRdata == ($past(addrProtected) ? VERIFY_PROTECTED
                                            : VERIFY_UNPROTECTED))
    else $error("verify read returned wrong protection data");

endmodule

`default_nettype wire

// *** fcs_pkg.sv ***
package fcs_pkg;

  // ==========================================================
  // Clock, widths and timing
  // ==========================================================
  localparam int CLK_MHZ = 100;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;
  localparam int APB_AW = 12;
  localparam int ERASE_HOLD_US = 50;
  localparam int ERASE_HOLD_CYC = ERASE_HOLD_US * CLK_MHZ;
  localparam int OP_TIMEOUT_US = 10000;
  localparam int OP_TIMEOUT_CYC = OP_TIMEOUT_US * CLK_MHZ;

  // ==========================================================
  // Register map (index, byte address is four times it)
  // ==========================================================
  localparam logic [11:0] REG_SEC_EN_IDX = 12'h16B;
  localparam logic [11:0] REG_STATUS_IDX = 12'h16E;
  localparam logic [7:0] SEC_EN_RESET = 8'h00;
  localparam logic [3:0] STATUS_SPARE_RESET = 4'h0;
  localparam int STATUS_SPARE_LSB = 4;
  localparam int STATUS_READY_POS = 2;
  localparam logic STATUS_READY_RESET = 1'b1;

  // ==========================================================
  // Command cycles
  // ==========================================================
  localparam logic [15:0] ADDR_UNLOCK_A = 16'hAAA8;
  localparam logic [15:0] ADDR_UNLOCK_B = 16'h5554;
  localparam logic [7:0] CMD_UNLOCK_A = 8'hAA;
  localparam logic [7:0] CMD_UNLOCK_B = 8'h55;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_BLOCK_ERASE = 8'h30;
  localparam logic [7:0] CMD_PROTECT_SETUP = 8'h9A;
  localparam logic [7:0] CMD_PROTECT_GO = 8'h70;
  localparam logic [7:0] CMD_VERIFY = 8'h90;
  localparam logic [7:0] CMD_RESET = 8'hF0;

  // ==========================================================
  // Status word layout and verify answers
  // ==========================================================
  localparam int POLL_POS = 7;
  localparam int TOGGLE_POS = 6;
  localparam int TIMEOUT_POS = 5;
  localparam int ERASE_TIMER_POS = 3;
  localparam logic [31:0] VERIFY_PROTECTED = 32'h0000_0001;
  localparam logic [31:0] VERIFY_UNPROTECTED = 32'h0000_0000;

  typedef enum logic [2:0] {
    OP_PROGRAM = 3'h0,
    OP_CHIP_ERASE = 3'h1,
    OP_CHIP_UNPROTECT = 3'h2,
    OP_BLOCK_ERASE = 3'h3,
    OP_PROTECT = 3'h4
  } fcs_op_type;

  function automatic logic [11:0] regByteAddr(input logic [11:0] idx);
    return {idx[9:0], 2'b00};
  endfunction

endpackage

// *** fcs_down_timer.sv ***
`timescale 1ns/1ps
`default_nettype none

module fcs_down_timer #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [WIDTH-1:0] loadValue,
  input wire logic clear,
  output logic done
);

  logic [WIDTH-1:0] count;
  logic active;

  // ==========================================================
  // Count down; done pulses loadValue cycles after the load
  // ==========================================================
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      active <= 1'b0;
    end else if (load) begin
      count <= loadValue;
      active <= 1'b1;
    end else if (clear) begin
      active <= 1'b0;
    end else if (active) begin
      count <= count - 1'b1;
      if (count == WIDTH'(1)) begin
        active <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done <= 1'b0;
    end else begin
      done <= active && !load && !clear && (count == WIDTH'(1));
    end
  end

endmodule

`default_nettype wire

// *** fcs_apb_regs.sv ***
`timescale 1ns/1ps
`default_nettype none

module fcs_apb_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fcs_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic readyBusy,
  output logic [7:0] securityEnable
);
  import fcs_pkg::*;

  logic [3:0] statusSpare;
  logic hitSec;
  logic hitStatus;
  logic writeNow;

  // ==========================================================
  // Decode; no wait states, unmapped access answers an error
  // ==========================================================
  assign hitSec = paddr == regByteAddr(REG_SEC_EN_IDX);
  assign hitStatus = paddr == regByteAddr(REG_STATUS_IDX);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(hitSec || hitStatus);
  assign writeNow = psel && penable && pwrite;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      securityEnable <= SEC_EN_RESET;
    end else if (writeNow && hitSec) begin
      securityEnable <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      statusSpare <= STATUS_SPARE_RESET;
    end else if (writeNow && hitStatus) begin
      statusSpare <= pwdata[STATUS_SPARE_LSB +: 4];
    end
  end

  // Read data is caught in the setup cycle so it leaves a flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= '0;
    end else if (psel && !penable) begin
      prdata <= '0;
      if (!pwrite && hitSec) begin
        prdata[7:0] <= securityEnable;
      end else if (!pwrite && hitStatus) begin
        prdata[STATUS_SPARE_LSB +: 4] <= statusSpare;
        prdata[STATUS_READY_POS] <= readyBusy;
      end
    end
  end

endmodule

`default_nettype wire

// *** fcs_engine_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module fcs_engine_model
  import fcs_pkg::*;
#(
  parameter int DELAY = 20
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic opStart,
  input wire fcs_pkg::fcs_op_type opKind,
  input wire logic [31:0] opData,
  output logic opDone,
  output logic [31:0] cellData
);
  // ========
  // Array engine
  // ========
  int count;
  logic busy;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      count <= 0;
      opDone <= 1'b0;
      cellData <= 32'hFFFF_FFFF;
    end else begin
      opDone <= 1'b0;
      if (opStart) begin
        busy <= 1'b1;
        count <= DELAY;
      end else if (busy && count == 0) begin
        busy <= 1'b0;
        opDone <= 1'b1;
        // Cells only ever clear; a set needs an erase
        if (opKind == OP_PROGRAM)
          cellData <= cellData & opData;
        else if (opKind != OP_PROTECT)
          cellData <= 32'hFFFF_FFFF;
      end else if (busy) begin
        count <= count - 1;
      end
    end
  end
endmodule
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fcs_pkg::*;
  // ========
  // Design and partner
  // ========
  localparam logic [11:0] SA = REG_STATUS_IDX << 2;
  localparam logic [11:0] EA = REG_SEC_EN_IDX << 2;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic flashWrite = 0, flashRead = 0, addrProt = 0, rdSeen = 0;
  logic [11:0] paddr = '0;
  logic [23:0] flashAddr = '0, opAddr;
  logic [31:0] pwdata = '0, flashWdata = '0, prdata, flashRdata;
  logic [31:0] cellData, opData, d, rnd, q[$];
  logic pready, pslverr, opStart, opDone, rdy;
  fcs_op_type opKind;
  int fail_count = 0, n_compared = 0, cyc = 0;
  always #5 clk = ~clk;
  fcs_sequencer #(.HOLD_CYCLES(8), .TIMEOUT_CYCLES(50)) fcs_sequencer_i (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flashWrite(flashWrite),
    .flashRead(flashRead), .flashAddr(flashAddr),
    .flashWdata(flashWdata), .flashRdata(flashRdata),
    .cellData(cellData), .addrProtected(addrProt), .opStart(opStart),
    .opKind(opKind), .opAddr(opAddr), .opData(opData),
    .opDone(opDone), .opError(1'b0), .readyBusyOutput(rdy));
  fcs_engine_model fcs_engine_model_i (.clk(clk), .rst_n(rst_n),
    .opStart(opStart), .opKind(opKind), .opData(opData),
    .opDone(opDone), .cellData(cellData));
  // ========
  // Checking
  // ========
  task results;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task cmp(input logic [31:0] got);
    logic [31:0] e;
    e = q.pop_front();
    n_compared++;
    if (got !== e) begin
      fail_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, e);
    end
  endtask
  task cmpBit(input logic got, input logic e);
    n_compared++;
    if (got !== e) begin
      fail_count++;
      $display("MISMATCH %0t flag %b exp %b", $time, got, e);
    end
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rdSeen) cmp(flashRdata);
    if (psel && penable && pready && !pwrite) cmp(prdata);
    if (psel && penable && pready) cmpBit(pslverr, paddr != SA && paddr != EA);
    if (opStart) cmpBit(opAddr == 24'h000100, 1'b1);
    rdSeen <= flashRead;
    if (cyc == 3000) begin
      fail_count++;
      results();
    end
  end
  // ========
  // Drivers
  // ========
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] st(input logic p, input logic [2:0] t);
    return {24'h0, p, t[2:1], 1'b0, t[0], 3'h0};
  endfunction
  task apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    if (!w) q.push_back(v);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clk) penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task fw(input logic [15:0] a, input logic [31:0] v);
    flashWrite <= 1;
    flashAddr <= {8'h00, a};
    flashWdata <= v;
    @(posedge clk) flashWrite <= 0;
    @(posedge clk);
  endtask
  task fr(input logic [31:0] e);
    q.push_back(e);
    flashRead <= 1;
    @(posedge clk) flashRead <= 0;
    @(posedge clk);
  endtask
  task fr2(input logic [31:0] e1, input logic [31:0] e2);
    q.push_back(e1);
    q.push_back(e2);
    flashRead <= 1;
    @(posedge clk);
    @(posedge clk) flashRead <= 0;
    @(posedge clk);
  endtask
  task unl;
    fw(ADDR_UNLOCK_A, 32'(CMD_UNLOCK_A));
    fw(ADDR_UNLOCK_B, 32'(CMD_UNLOCK_B));
  endtask
  task seq(input logic [7:0] c);
    unl();
    fw(ADDR_UNLOCK_A, 32'(c));
  endtask
  task waitRdy;
    for (int i = 0; i < 200 && rdy !== 1'b1; i++) @(posedge clk);
  endtask
  initial begin
    rnd = 32'h30AE;
    repeat (5) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    apb(0, SA, 32'h4);
    apb(0, EA, 32'h0);
    apb(1, EA, 32'hFF);
    apb(0, EA, 32'hFF);
    apb(1, SA, 32'hF0);
    apb(0, SA, 32'hF4);
    apb(0, 12'h000, 32'h0);
    rnd = lfsr(rnd);
    d = rnd & 32'hFFFF_FFFE;
    seq(CMD_PROGRAM);
    fw(16'h0100, d);
    fr(st(~d[7], 3'b000));
    fr(st(~d[7], 3'b100));
    apb(0, SA, 32'hF0);
    waitRdy();
    fr(d);
    seq(CMD_PROGRAM);
    fw(16'h0100, 32'hFFFF_FFFF);
    fr(st(1'b0, 3'b000));
    repeat (60) @(posedge clk);
    fr2(st(1'b0, 3'b110), st(1'b0, 3'b010));
    fr(st(1'b0, 3'b110));
    apb(0, SA, 32'hF0);
    fw(16'h0000, 32'(CMD_RESET));
    fr(d);
    seq(CMD_ERASE_SETUP);
    unl();
    fw(16'h0100, 32'(CMD_BLOCK_ERASE));
    repeat (12) @(posedge clk);
    fr(st(1'b0, 3'b001));
    waitRdy();
    fr(32'hFFFF_FFFF);
    seq(CMD_PROGRAM);
    fw(16'h0100, 32'hFFFF_FFF0);
    waitRdy();
    fr(32'hFFFF_FFF0);
    fw(ADDR_UNLOCK_A, 32'(CMD_UNLOCK_A));
    fw(ADDR_UNLOCK_B, 32'h56);
    fr(32'hFFFF_FFF0);
    seq(CMD_VERIFY);
    fr(VERIFY_UNPROTECTED);
    addrProt <= 1;
    fr(VERIFY_PROTECTED);
    fw(16'h0000, 32'(CMD_RESET));
    fr(32'hFFFF_FFF0);
    results();
  end
endmodule
`default_nettype wire
